// File: rtl/conv_sys_exec.sv
`timescale 1ns/10ps
`include "conv_sys_exec_regs.svh"
module conv_sys_exec
  import conv_sys_exec_pkg::*;
#(
  parameter int PC_W    = 12,
  parameter bit HAS_LVD = 1'b1
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  // axi4-lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic [2:0]  ARPROT,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // converter side
  input  wire logic [9:0]  CONV_RESULT,
  input  wire logic        CONV_DONE,
  output logic             CONV_START,
  output logic             CMP_START,
  output logic [7:0]       CMP_VALUE,
  output logic             UPPER_REF,
  // system side
  input  wire logic        WDT_EXPIRE,
  input  wire logic        BACKUP_RETURN,
  output logic             WDT_STOP,
  output logic             BACKUP_ENTER,
  output logic             LVD_ENABLE,
  output logic             SOFT_RESET
);

  // elaboration check
  if (PC_W < 4 || PC_W > 16) begin : g_bad_pc
    $error("PC_W must lie between 4 and 16");
  end

  // address decode shared by both bus directions
  function automatic reg_sel_e reg_sel(input logic [7:0] addr);
    if (addr == `OFF_CMD) begin
      return SEL_CMD;
    end else if (addr == `OFF_ACC) begin
      return SEL_ACC;
    end else if (addr == `OFF_CTRL) begin
      return SEL_CTRL;
    end else if (addr == `OFF_STATUS) begin
      return SEL_STATUS;
    end else if (addr == `OFF_COMPARE) begin
      return SEL_COMPARE;
    end else if (addr == `OFF_RESULT) begin
      return SEL_RESULT;
    end else if (addr == `OFF_PC) begin
      return SEL_PC;
    end else begin
      return SEL_NONE;
    end
  endfunction

  logic              awready_reg;
  logic              wready_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [3:0]        a_reg;
  logic [3:0]        b_reg;
  logic [3:0]        conv_ctrl_reg;
  logic [3:0]        irq_ctrl_two_reg;
  logic [7:0]        cmp_reg;
  logic              done_reg;
  logic              watchdog_flag_one_reg;
  logic              upper_reg;
  logic              skip_reg;
  arm_s              arm_reg;
  core_state_e       core_reg;
  logic              backup_reg;
  logic              wdt_stop_reg;
  logic              lvd_reg;
  logic              conv_start_reg;
  logic              cmp_start_reg;
  logic              soft_reset_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [9:0]        last_op_reg;
  logic              wr_go;
  reg_sel_e          wr_sel;
  logic              cmd_in;
  logic              exec;
  logic [9:0]        op;
  logic              mode_cmp;
  logic              sys_clr;
  logic [31:0]       rd_mux;
  logic [15:0]       status_word;

  // write channel: address and data taken in either order
  assign wr_go  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_sel = reg_sel(awaddr_reg);

  // address and data capture
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (AWVALID && awready_reg) begin
        awaddr_reg  <= AWADDR;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end else if (wr_go) begin
        aw_full_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        awready_reg <= 1'b1;
      end
      if (WVALID && wready_reg) begin
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end else if (wr_go) begin
        w_full_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (BVALID && BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // an instruction word arrives through the command register
  assign cmd_in   = wr_go && wr_sel == SEL_CMD && wstrb_reg[1:0] == 2'h3;
  assign op       = wdata_reg[9:0];
  // back-up state halts every instruction until reset
  assign exec     = cmd_in && core_reg == CORE_RUN && !skip_reg;
  assign mode_cmp = conv_ctrl_reg[`MODE_BIT];
  assign sys_clr  = exec && op == `OP_SOFTWARE_RESET;

  // program counter, skip and last instruction
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      pc_reg      <= '0;
      skip_reg    <= 1'b0;
      last_op_reg <= `RST_OP;
    end else if (sys_clr) begin
      pc_reg      <= '0;
      skip_reg    <= 1'b0;
      last_op_reg <= `RST_OP;
    end else if (cmd_in && core_reg == CORE_RUN) begin
      pc_reg      <= pc_reg + 1'b1;
      last_op_reg <= op;
      skip_reg    <= 1'b0;
      if (exec) begin
        case (op)
          `OP_SKIP_IF_DONE: skip_reg <= !irq_ctrl_two_reg[`IRQ_SEL_BIT]
                                        && done_reg;
          `OP_SKIP_IF_WARM: skip_reg <= BACKUP_RETURN;
          `OP_WDT_SERVICE:  skip_reg <= watchdog_flag_one_reg;
          default:          skip_reg <= 1'b0;
        endcase
      end
    end
  end

  // one-shot arming: any executed instruction consumes it
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      arm_reg <= '0;
    end else if (sys_clr) begin
      arm_reg <= '0;
    end else if (cmd_in && core_reg == CORE_RUN) begin
      arm_reg.backup   <= exec && op == `OP_ARM_BACKUP;
      arm_reg.wdt_stop <= exec && op == `OP_ARM_WDT_STOP;
    end
  end

  // accumulator pair: instructions and direct bus writes
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      a_reg <= `RST_NIBBLE;
      b_reg <= `RST_NIBBLE;
    end else if (sys_clr) begin
      a_reg <= `RST_NIBBLE;
      b_reg <= `RST_NIBBLE;
    end else if (exec) begin
      case (op)
        `OP_READ_RESULT_UPPER: begin
          if (mode_cmp) begin
            b_reg <= cmp_reg[7:4];
            a_reg <= cmp_reg[3:0];
          end else begin
            b_reg <= CONV_RESULT[9:6];
            a_reg <= CONV_RESULT[5:2];
          end
        end
        `OP_READ_RESULT_LOW: begin
          a_reg <= {CONV_RESULT[1:0], a_reg[1], 1'b0};
        end
        `OP_READ_CONV_CTRL: a_reg <= conv_ctrl_reg;
        default: ;
      endcase
    end else if (wr_go && wr_sel == SEL_ACC && wstrb_reg[0]) begin
      a_reg <= wdata_reg[`ACC_A_LSB +: 4];
      b_reg <= wdata_reg[`ACC_B_LSB +: 4];
    end
  end

  // converter control and interrupt control two
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      conv_ctrl_reg    <= `RST_NIBBLE;
      irq_ctrl_two_reg <= `RST_NIBBLE;
    end else if (sys_clr) begin
      conv_ctrl_reg    <= `RST_NIBBLE;
      irq_ctrl_two_reg <= `RST_NIBBLE;
    end else if (exec && op == `OP_WRITE_CONV_CTRL) begin
      conv_ctrl_reg <= a_reg;
    end else if (wr_go && wr_sel == SEL_CTRL && wstrb_reg[0]) begin
      conv_ctrl_reg    <= wdata_reg[`CTRL_CONV_LSB +: 4];
      irq_ctrl_two_reg <= wdata_reg[`CTRL_IRQ2_LSB +: 4];
    end
  end

  // comparator register
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cmp_reg <= `RST_CMP;
    end else if (sys_clr) begin
      cmp_reg <= `RST_CMP;
    end else if (exec && op == `OP_WRITE_COMPARATOR) begin
      if (mode_cmp) begin
        cmp_reg <= {b_reg, a_reg};
      end
    end else if (wr_go && wr_sel == SEL_COMPARE && wstrb_reg[0]) begin
      cmp_reg <= wdata_reg[7:0];
    end
  end

  // done flag: a completion in a start or skip clearing cycle wins
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      done_reg <= 1'b0;
    end else if (sys_clr) begin
      done_reg <= 1'b0;
    end else if (CONV_DONE) begin
      done_reg <= 1'b1;
    end else if (exec && op == `OP_START_CONVERSION) begin
      done_reg <= 1'b0;
    end else if (exec && op == `OP_SKIP_IF_DONE &&
                 !irq_ctrl_two_reg[`IRQ_SEL_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // start pulses steered by mode
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      conv_start_reg <= 1'b0;
      cmp_start_reg  <= 1'b0;
    end else begin
      conv_start_reg <= exec && op == `OP_START_CONVERSION
                        && !mode_cmp;
      cmp_start_reg  <= exec && op == `OP_START_CONVERSION
                        && mode_cmp;
    end
  end

  // watchdog flag one and watchdog stop
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      watchdog_flag_one_reg     <= 1'b0;
      wdt_stop_reg <= 1'b0;
    end else if (sys_clr) begin
      watchdog_flag_one_reg     <= 1'b0;
      wdt_stop_reg <= 1'b0;
    end else begin
      if (WDT_EXPIRE) begin
        watchdog_flag_one_reg <= 1'b1;
      end else if (exec && op == `OP_WDT_SERVICE) begin
        watchdog_flag_one_reg <= 1'b0;
      end
      if (exec && op == `OP_WDT_SERVICE && arm_reg.wdt_stop) begin
        wdt_stop_reg <= 1'b1;
      end
    end
  end

  // upper reference flag and low-voltage watch
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      upper_reg <= 1'b0;
      lvd_reg   <= 1'b0;
    end else if (sys_clr) begin
      upper_reg <= 1'b0;
      lvd_reg   <= 1'b0;
    end else if (exec) begin
      if (op == `OP_CLEAR_UPPER_REF) begin
        upper_reg <= 1'b0;
      end else if (op == `OP_SET_UPPER_REF) begin
        upper_reg <= 1'b1;
      end else if (op == `OP_LOW_VOLTAGE_WATCH && HAS_LVD) begin
        lvd_reg <= 1'b1;
      end
    end
  end

  // back-up entry and software reset pulse
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      core_reg       <= CORE_RUN;
      backup_reg     <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= sys_clr;
      if (exec && op == `OP_ENTER_BACKUP && arm_reg.backup) begin
        core_reg   <= CORE_BACKUP;
        backup_reg <= 1'b1;
      end
    end
  end

  // status word for reads
  assign status_word = {6'h00, arm_reg.wdt_stop, arm_reg.backup, skip_reg,
                        lvd_reg, wdt_stop_reg, core_reg == CORE_BACKUP,
                        upper_reg, BACKUP_RETURN, watchdog_flag_one_reg, done_reg};

  // read data multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_sel(ARADDR))
      SEL_CMD:     rd_mux[9:0]   = last_op_reg;
      SEL_ACC:     rd_mux[7:0]   = {b_reg, a_reg};
      SEL_CTRL:    rd_mux[7:0]   = {irq_ctrl_two_reg, conv_ctrl_reg};
      SEL_STATUS:  rd_mux[15:0]  = status_word;
      SEL_COMPARE: rd_mux[7:0]   = cmp_reg;
      SEL_RESULT:  rd_mux[9:0]   = CONV_RESULT;
      SEL_PC:      rd_mux[PC_W-1:0] = pc_reg;
      default:     rd_mux        = 32'h0000_0000;
    endcase
  end

  // read channel
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else if (ARVALID && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= (reg_sel(ARADDR) == SEL_NONE) ? `RESP_SLVERR
                                                   : `RESP_OKAY;
    end else if (RVALID && RREADY) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // outputs straight from flops
  assign AWREADY      = awready_reg;
  assign WREADY       = wready_reg;
  assign BVALID       = bvalid_reg;
  assign BRESP        = bresp_reg;
  assign ARREADY      = arready_reg;
  assign RVALID       = rvalid_reg;
  assign RRESP        = rresp_reg;
  assign RDATA        = rdata_reg;
  assign CONV_START   = conv_start_reg;
  assign CMP_START    = cmp_start_reg;
  assign CMP_VALUE    = cmp_reg;
  assign UPPER_REF    = upper_reg;
  assign WDT_STOP     = wdt_stop_reg;
  assign BACKUP_ENTER = backup_reg;
  assign LVD_ENABLE   = lvd_reg;
  assign SOFT_RESET   = soft_reset_reg;

endmodule // conv_sys_exec

// File: rtl/conv_sys_exec_regs.svh
`ifndef CONV_SYS_EXEC_REGS_SVH
`define CONV_SYS_EXEC_REGS_SVH

// register byte offsets
`define OFF_CMD      8'h00
`define OFF_ACC      8'h04
`define OFF_CTRL     8'h08
`define OFF_STATUS   8'h0C
`define OFF_COMPARE  8'h10
`define OFF_RESULT   8'h14
`define OFF_PC       8'h18

// field positions
`define ACC_A_LSB       0
`define ACC_B_LSB       4
`define CTRL_CONV_LSB   0
`define CTRL_IRQ2_LSB   4
`define MODE_BIT        3
`define IRQ_SEL_BIT     2
`define ST_DONE         0
`define ST_WATCHDOG_FLAG_ONE         1
`define ST_WARM         2
`define ST_UPPER        3
`define ST_BACKUP       4
`define ST_WDT_STOP     5
`define ST_LVD          6
`define ST_SKIP         7
`define ST_ARM_BACKUP   8
`define ST_ARM_WDT      9

// reset values
`define RST_NIBBLE   4'h0
`define RST_CMP      8'h00
`define RST_OP       10'h000

// bus answers
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// instruction codes
`define OP_READ_RESULT_UPPER   10'h279
`define OP_READ_RESULT_LOW     10'h249
`define OP_WRITE_COMPARATOR    10'h239
`define OP_READ_CONV_CTRL      10'h244
`define OP_WRITE_CONV_CTRL     10'h204
`define OP_START_CONVERSION    10'h29F
`define OP_SKIP_IF_DONE        10'h287
`define OP_NO_OPERATION        10'h000
`define OP_ENTER_BACKUP        10'h002
`define OP_ARM_BACKUP          10'h05B
`define OP_SKIP_IF_WARM        10'h003
`define OP_ARM_WDT_STOP        10'h29C
`define OP_WDT_SERVICE         10'h2A0
`define OP_SOFTWARE_RESET      10'h001
`define OP_CLEAR_UPPER_REF     10'h058
`define OP_SET_UPPER_REF       10'h059
`define OP_LOW_VOLTAGE_WATCH   10'h293

`endif

// File: rtl/conv_sys_exec_pkg.sv
package conv_sys_exec_pkg;
  // register selected by a bus address
  typedef enum {
    SEL_CMD, SEL_ACC, SEL_CTRL, SEL_STATUS, SEL_COMPARE, SEL_RESULT,
    SEL_PC, SEL_NONE
  } reg_sel_e;

  // core run state
  typedef enum {CORE_RUN, CORE_BACKUP} core_state_e;

  // one-shot arming of the follow-on instruction
  typedef struct packed {
    logic backup;
    logic wdt_stop;
  } arm_s;
endpackage

// File: verification/conv_sys_exec_monitor.sv
`timescale 1ns/10ps
`include "conv_sys_exec_regs.svh"
module conv_sys_exec_monitor (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  // write channels
  input wire logic [7:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  WSTRB,
  input wire logic        WVALID,
  input wire logic        WREADY,
  // block outputs
  input wire logic        CONV_START,
  input wire logic        CMP_START,
  input wire logic [7:0]  CMP_VALUE,
  input wire logic        UPPER_REF,
  input wire logic        WDT_STOP,
  input wire logic        BACKUP_ENTER,
  input wire logic        LVD_ENABLE,
  input wire logic        SOFT_RESET
);
  logic       cmd_take;
  logic [9:0] op;
  // instruction word taken on the command register
  assign cmd_take = AWVALID && AWREADY && WVALID && WREADY
                    && AWADDR == `OFF_CMD && WSTRB[1:0] == 2'h3;
  assign op = WDATA[9:0];
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // effects land two edges after the take
  chk_upper_set: assert property ($rose(UPPER_REF) |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_SET_UPPER_REF)
    else $error("upper reference rose without its instruction");
  chk_upper_clear: assert property ($fell(UPPER_REF) |->
    $past(cmd_take, 2) && ($past(op, 2) == `OP_CLEAR_UPPER_REF || SOFT_RESET))
    else $error("upper reference fell without its instruction");
  chk_conv_start: assert property (CONV_START |-> !CMP_START &&
    $past(cmd_take, 2) && $past(op, 2) == `OP_START_CONVERSION)
    else $error("conversion start without start instruction");
  chk_cmp_start: assert property (CMP_START |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_START_CONVERSION)
    else $error("comparator start without start instruction");
  chk_start_pulse: assert property (CONV_START || CMP_START |=>
    !CONV_START && !CMP_START)
    else $error("start pulse longer than one cycle");
  chk_soft_clear: assert property (SOFT_RESET |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_SOFTWARE_RESET && !UPPER_REF
    && !WDT_STOP && !LVD_ENABLE && CMP_VALUE == `RST_CMP)
    else $error("software reset did not restore state");
  chk_wdt_stop: assert property ($rose(WDT_STOP) |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_WDT_SERVICE)
    else $error("watchdog stopped without service instruction");
  chk_lvd_on: assert property ($rose(LVD_ENABLE) |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_LOW_VOLTAGE_WATCH)
    else $error("drop detection enabled without its instruction");
  chk_backup_entry: assert property ($rose(BACKUP_ENTER) |->
    $past(cmd_take, 2) && $past(op, 2) == `OP_ENTER_BACKUP)
    else $error("back-up entered without its instruction");
  chk_backup_hold: assert property (BACKUP_ENTER |=> BACKUP_ENTER &&
    !CONV_START && !CMP_START && !SOFT_RESET)
    else $error("activity while in back-up state");
  // main scenarios reached
  cov_cmp_start: cover property (CMP_START);
  cov_soft_reset: cover property (SOFT_RESET);
  cov_wdt_stop: cover property ($rose(WDT_STOP));
  cov_backup: cover property ($rose(BACKUP_ENTER));
endmodule // conv_sys_exec_monitor

bind conv_sys_exec conv_sys_exec_monitor u_mon (.CLK_SYS, .RST_B, .AWADDR,
  .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .CONV_START,
  .CMP_START, .CMP_VALUE, .UPPER_REF, .WDT_STOP, .BACKUP_ENTER, .LVD_ENABLE,
  .SOFT_RESET);

// File: verification/conv_sys_exec_bench.sv
`timescale 1ns/10ps
`include "conv_sys_exec_regs.svh"
module conv_sys_exec_bench;
  logic        CLK_SYS, RST_B, CONV_DONE, WDT_EXPIRE, BACKUP_RETURN;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, CONV_START, CMP_START;
  logic        UPPER_REF, WDT_STOP, BACKUP_ENTER, LVD_ENABLE, SOFT_RESET;
  logic [7:0]  AWADDR, ARADDR, CMP_VALUE;
  logic [2:0]  AWPROT, ARPROT;
  logic [31:0] WDATA, RDATA, rdv;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [9:0]  CONV_RESULT;
  int          bad_count, comparisons, conv_cnt, cmp_cnt, soft_cnt;

  conv_sys_exec u_dut (.CLK_SYS, .RST_B, .AWADDR, .AWPROT, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARPROT, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .CONV_RESULT, .CONV_DONE, .CONV_START, .CMP_START, .CMP_VALUE,
    .UPPER_REF, .WDT_EXPIRE, .BACKUP_RETURN, .WDT_STOP, .BACKUP_ENTER,
    .LVD_ENABLE, .SOFT_RESET);

  // 20 MHz system clock
  always #25 CLK_SYS = ~CLK_SYS;

  // count one-cycle pulses mid-cycle, where they are settled
  always @(negedge CLK_SYS) begin
    if (CONV_START === 1'b1) conv_cnt++;
    if (CMP_START === 1'b1) cmp_cnt++;
    if (SOFT_RESET === 1'b1) soft_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, bready held to response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask

  // read: rready held until data arrives
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rdv = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask

  task automatic cmd(input logic [9:0] op);
    wr(`OFF_CMD, {22'h0, op});
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #500000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end

  initial begin
    {CLK_SYS, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {CONV_DONE, WDT_EXPIRE, BACKUP_RETURN, AWADDR, ARADDR} = '0;
    {AWPROT, ARPROT, WDATA} = '0;
    WSTRB = 4'hF;
    CONV_RESULT = 10'h2B6;
    repeat (4) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    // reset values and unmapped place
    rc(`OFF_ACC, 32'h0);
    rc(`OFF_CTRL, 32'h0);
    rc(`OFF_COMPARE, 32'h0);
    rc(`OFF_PC, 32'h0);
    rc(`OFF_RESULT, 32'h2B6);
    rd(8'h1C);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    wr(8'h1C, 32'h1);
    chk(32'(rsp), 32'(`RESP_SLVERR));
    tend("reset");
    // conversion mode reads
    cmd(`OP_READ_RESULT_UPPER);
    rc(`OFF_ACC, 32'hAD);
    cmd(`OP_READ_RESULT_LOW);
    rc(`OFF_ACC, 32'hA8);
    rc(`OFF_CMD, 32'h249);
    cmd(`OP_WRITE_COMPARATOR);
    rc(`OFF_COMPARE, 32'h0);
    rc(`OFF_PC, 32'h3);
    cmd(`OP_NO_OPERATION);
    rc(`OFF_PC, 32'h4);
    rc(`OFF_ACC, 32'hA8);
    tend("conversion reads");
    // control register and comparator mode
    wr(`OFF_ACC, 32'h58);
    cmd(`OP_WRITE_CONV_CTRL);
    rc(`OFF_CTRL, 32'h08);
    wr(`OFF_ACC, 32'h50);
    cmd(`OP_READ_CONV_CTRL);
    rc(`OFF_ACC, 32'h58);
    wr(`OFF_ACC, 32'h3C);
    cmd(`OP_WRITE_COMPARATOR);
    chk(32'(CMP_VALUE), 32'h3C);
    wr(`OFF_ACC, 32'h0);
    cmd(`OP_READ_RESULT_UPPER);
    rc(`OFF_ACC, 32'h3C);
    tend("comparator mode");
    // start in both modes; comparator-mode start clears done
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b1;
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b0;
    cmd(`OP_START_CONVERSION);
    rd(`OFF_STATUS);
    chk(32'(rdv[0]), 32'h0);
    chk(32'(cmp_cnt), 32'h1);
    wr(`OFF_CTRL, 32'h0);
    cmd(`OP_START_CONVERSION);
    chk(32'(conv_cnt), 32'h1);
    tend("start");
    // skip on done, then with irq select set
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b1;
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b0;
    cmd(`OP_SKIP_IF_DONE);
    rd(`OFF_STATUS);
    chk(32'(rdv[0]), 32'h0);
    cmd(`OP_SET_UPPER_REF);
    chk(32'(UPPER_REF), 32'h0);
    cmd(`OP_SKIP_IF_DONE);
    cmd(`OP_SET_UPPER_REF);
    chk(32'(UPPER_REF), 32'h1);
    cmd(`OP_CLEAR_UPPER_REF);
    chk(32'(UPPER_REF), 32'h0);
    wr(`OFF_CTRL, 32'h40);
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b1;
    @(posedge CLK_SYS);
    CONV_DONE <= 1'b0;
    cmd(`OP_SKIP_IF_DONE);
    rd(`OFF_STATUS);
    chk(32'(rdv[0]), 32'h1);
    cmd(`OP_SET_UPPER_REF);
    chk(32'(UPPER_REF), 32'h1);
    tend("skip on done");
    // skip on warm return flag
    BACKUP_RETURN <= 1'b1;
    cmd(`OP_SKIP_IF_WARM);
    cmd(`OP_CLEAR_UPPER_REF);
    chk(32'(UPPER_REF), 32'h1);
    BACKUP_RETURN <= 1'b0;
    cmd(`OP_SKIP_IF_WARM);
    cmd(`OP_CLEAR_UPPER_REF);
    chk(32'(UPPER_REF), 32'h0);
    tend("skip on warm");
    // watchdog service and stop arming
    @(posedge CLK_SYS);
    WDT_EXPIRE <= 1'b1;
    @(posedge CLK_SYS);
    WDT_EXPIRE <= 1'b0;
    cmd(`OP_WDT_SERVICE);
    rd(`OFF_STATUS);
    chk(32'(rdv[1]), 32'h0);
    cmd(`OP_SET_UPPER_REF);
    chk(32'(UPPER_REF), 32'h0);
    cmd(`OP_ARM_WDT_STOP);
    cmd(`OP_NO_OPERATION);
    cmd(`OP_WDT_SERVICE);
    chk(32'(WDT_STOP), 32'h0);
    cmd(`OP_ARM_WDT_STOP);
    cmd(`OP_WDT_SERVICE);
    chk(32'(WDT_STOP), 32'h1);
    cmd(`OP_LOW_VOLTAGE_WATCH);
    chk(32'(LVD_ENABLE), 32'h1);
    cmd(`OP_SET_UPPER_REF);
    tend("watchdog");
    // software reset restores state
    cmd(`OP_SOFTWARE_RESET);
    chk(32'(soft_cnt), 32'h1);
    chk(32'({UPPER_REF, WDT_STOP, LVD_ENABLE, CMP_VALUE}), 32'h0);
    rc(`OFF_PC, 32'h0);
    rc(`OFF_ACC, 32'h0);
    tend("software reset");
    // back-up entry only when armed just before
    cmd(`OP_ENTER_BACKUP);
    chk(32'(BACKUP_ENTER), 32'h0);
    cmd(`OP_ARM_BACKUP);
    cmd(`OP_NO_OPERATION);
    cmd(`OP_ENTER_BACKUP);
    chk(32'(BACKUP_ENTER), 32'h0);
    cmd(`OP_ARM_BACKUP);
    cmd(`OP_ENTER_BACKUP);
    chk(32'(BACKUP_ENTER), 32'h1);
    cmd(`OP_SET_UPPER_REF);
    chk(32'(UPPER_REF), 32'h0);
    rc(`OFF_PC, 32'h6);
    tend("back-up");
    final_report;
  end
endmodule // conv_sys_exec_bench
